/* verilog/sarc_top.sv */
// Convert/read control, result buffer and three-state parallel output
`timescale 1ns/100ps

// Function
// - Both lines low puts sample-and-hold in hold and starts converting.
// - Busy goes low at start, rises after the result register updates.
// - Result is two's complement, MSB on the top data line.
// - Convert commands are ignored while busy is low.
// - At conversion end the sample-and-hold returns to tracking.
// - Select and read/convert are a level OR; both low starts, any order.
// - Select high: no action, data bus floats.
// - Select falling with read/convert low starts a conversion, bus floats.
// - Read/convert falling with select low starts a conversion, bus floats.
// - Select low, read/convert high: new result appears as busy rises.
// - Select falling with read/convert high when idle drives latest result.
// - Reading during a conversion returns the previous result.
// - Select tied low: bus driven when read/convert high, floats when low.
// - Byte select low gives upper byte on the lanes, high the lower byte.
// - Previous result stays valid after a start until one cycle before busy rises.
module sarc_top
   import sarc_pkg::*;
(
   // Clock and reset
   input wire logic CLK_SYS_IN,
   input wire logic RST_N_IN,
   // Host control pins
   input wire logic CS_N_IN,
   input wire logic RD_CONV_N_IN,
   input wire logic BYTE_SEL_IN,
   // Result stream from the approximation core
   input wire logic [RESULT_W-1:0] RESULT_DATA_IN,
   input wire logic RESULT_VALID_IN,
   output logic RESULT_READY_OUT,
   // Status and analog control
   output logic BUSY_N_OUT,
   output logic HOLD_OUT,
   // Parallel data bus
   output logic [RESULT_W-1:0] DATA_OUT,
   output logic DATA_OE_N_OUT
);
   // ----------------------------------------------------------------
   // Reset release and pin synchronisers
   // ----------------------------------------------------------------
   logic rst_meta;
   logic rst_n;
   logic [1:0] cs_pipe;
   logic [1:0] rc_pipe;
   logic [1:0] byte_pipe;
   logic cs_s;
   logic rc_s;
   logic byte_s;

   always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // Only the second stage is ever read
   always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
      if (!rst_n) begin
         cs_pipe <= LEVEL_RST;
         rc_pipe <= LEVEL_RST;
         byte_pipe <= 2'h0;
      end else begin
         cs_pipe <= {cs_pipe[0], CS_N_IN};
         rc_pipe <= {rc_pipe[0], RD_CONV_N_IN};
         byte_pipe <= {byte_pipe[0], BYTE_SEL_IN};
      end
   end

   assign cs_s = cs_pipe[1];
   assign rc_s = rc_pipe[1];
   assign byte_s = byte_pipe[1];

   // ----------------------------------------------------------------
   // Two-entry result buffer
   // ----------------------------------------------------------------
   logic [RESULT_W-1:0] buf_word [BUF_DEPTH];
   logic [RESULT_W-1:0] next_buf_word [BUF_DEPTH];
   logic [1:0] buf_cnt;
   logic [1:0] next_buf_cnt;
   logic buf_wr;
   logic next_buf_wr;
   logic buf_rd;
   logic next_buf_rd;
   logic next_ready;
   logic push;
   logic pop;
   logic buf_valid;

   assign buf_valid = (buf_cnt != 2'h0);
   assign push = RESULT_VALID_IN && RESULT_READY_OUT;

   // Core stalls once both entries wait for a slow conversion end
   always_comb begin
      next_buf_word = buf_word;
      next_buf_wr = buf_wr;
      next_buf_rd = buf_rd;
      next_buf_cnt = buf_cnt;
      if (push) begin
         next_buf_word[buf_wr] = RESULT_DATA_IN;
         next_buf_wr = ~buf_wr;
      end
      if (pop) begin
         next_buf_rd = ~buf_rd;
      end
      next_buf_cnt = buf_cnt + {1'b0, push} - {1'b0, pop};
      next_ready = (next_buf_cnt != 2'(BUF_DEPTH));
   end

   always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
      if (!rst_n) begin
         buf_word[0] <= RESULT_RST;
         buf_word[1] <= RESULT_RST;
         buf_cnt <= 2'h0;
         buf_wr <= 1'b0;
         buf_rd <= 1'b0;
         RESULT_READY_OUT <= 1'b0;
      end else begin
         buf_word <= next_buf_word;
         buf_cnt <= next_buf_cnt;
         buf_wr <= next_buf_wr;
         buf_rd <= next_buf_rd;
         RESULT_READY_OUT <= next_ready;
      end
   end

   // ----------------------------------------------------------------
   // Conversion sequencer
   // ----------------------------------------------------------------
   sarc_state_t state;
   sarc_state_t next_state;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic [RESULT_W-1:0] result;
   logic [RESULT_W-1:0] next_result;
   logic next_busy_n;
   logic next_hold;
   logic start;

   // Level OR of both lines; only looked at while tracking
   assign start = !cs_s && !rc_s;

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_result = result;
      next_busy_n = BUSY_N_OUT;
      next_hold = HOLD_OUT;
      pop = 1'b0;
      unique case (state)
         SARC_TRACK: begin
            // Lines still low after release restart at once, unacquired
            if (start) begin
               next_state = SARC_CONVERT;
               next_cnt = CNT_RST;
               next_hold = 1'b1;
               next_busy_n = 1'b0;
            end
         end
         SARC_CONVERT: begin
            // Pins are not looked at here, so commands are dropped
            if (cnt != CONV_LAST) begin
               next_cnt = cnt + 11'h001;
            end else if (buf_valid) begin
               next_result = buf_word[buf_rd];
               pop = 1'b1;
               next_state = SARC_RELEASE;
            end
         end
         SARC_RELEASE: begin
            next_busy_n = 1'b1;
            next_hold = 1'b0;
            next_state = SARC_TRACK;
         end
         default: begin
            next_state = SARC_TRACK;
         end
      endcase
   end

   always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
      if (!rst_n) begin
         state <= SARC_TRACK;
         cnt <= CNT_RST;
         result <= RESULT_RST;
         BUSY_N_OUT <= 1'b1;
         HOLD_OUT <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         result <= next_result;
         BUSY_N_OUT <= next_busy_n;
         HOLD_OUT <= next_hold;
      end
   end

   // ----------------------------------------------------------------
   // Parallel output
   // ----------------------------------------------------------------
   logic [RESULT_W-1:0] next_data;
   logic next_oe_n;

   // Data follows next_result so the new word lands with result, one cycle before busy rises
   always_comb begin
      next_data = sarc_lanes(next_result, byte_s);
      next_oe_n = !(!cs_s && rc_s);
   end

   always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
      if (!rst_n) begin
         DATA_OUT <= RESULT_RST;
         DATA_OE_N_OUT <= 1'b1;
      end else begin
         DATA_OUT <= next_data;
         DATA_OE_N_OUT <= next_oe_n;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence seq_start;
      state == SARC_TRACK && start;
   endsequence

   sequence seq_busy_low_run;
      (!BUSY_N_OUT && HOLD_OUT) [*8];
   endsequence

   chk_start_busy_low: assert property (
      @(posedge CLK_SYS_IN) disable iff (!rst_n)
      seq_start |=> seq_busy_low_run)
      else $error("busy or hold did not follow a start");

   chk_hold_tracks_busy: assert property (
      @(posedge CLK_SYS_IN) disable iff (!rst_n)
      HOLD_OUT == !BUSY_N_OUT)
      else $error("hold and busy disagree");

   chk_ignore_commands: assert property (
      @(posedge CLK_SYS_IN) disable iff (!rst_n)
      state == SARC_CONVERT && cnt != CONV_LAST |=> state == SARC_CONVERT)
      else $error("conversion cut short by a command");

   chk_float_cs_high: assert property (
      @(posedge CLK_SYS_IN) disable iff (!rst_n)
      cs_s |=> DATA_OE_N_OUT)
      else $error("bus driven with select high");

   chk_float_convert: assert property (
      @(posedge CLK_SYS_IN) disable iff (!rst_n)
      !cs_s && !rc_s |=> DATA_OE_N_OUT)
      else $error("bus driven while convert line low");

   chk_drive_read: assert property (
      @(posedge CLK_SYS_IN) disable iff (!rst_n)
      !cs_s && rc_s |=> !DATA_OE_N_OUT)
      else $error("bus not driven in read mode");

   chk_result_at_busy: assert property (
      @(posedge CLK_SYS_IN) disable iff (!rst_n)
      $rose(BUSY_N_OUT) |-> $past(state) == SARC_RELEASE
                            && DATA_OUT == sarc_lanes(result, $past(byte_s)))
      else $error("new result not on bus as busy rises");

   chk_prev_result_held: assert property (
      @(posedge CLK_SYS_IN) disable iff (!rst_n)
      state == SARC_CONVERT && !pop |=> $stable(result))
      else $error("result changed during conversion");

   chk_byte_lanes: assert property (
      @(posedge CLK_SYS_IN) disable iff (!rst_n)
      !pop |=> DATA_OUT == ($past(byte_s) ?
                            {$past(result[BYTE_W-1:0]), $past(result[RESULT_W-1:BYTE_W])} :
                            $past(result)))
      else $error("wrong byte lane placement");
endmodule

/* verilog/sarc_pkg.sv */
// Shared constants, types and lane function of the converter control block
package sarc_pkg;
   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int RESULT_W = 16;
   localparam int BYTE_W = 8;
   localparam int CNT_W = 11;
   localparam int BUF_DEPTH = 2;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 4;
   localparam int CONV_TIME_NS = 7600;
   // Least time, so round up
   localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYC - 1);
   localparam logic [CNT_W-1:0] CNT_RST = 11'h000;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [RESULT_W-1:0] RESULT_RST = 16'h0000;
   localparam logic [1:0] LEVEL_RST = 2'h3;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {SARC_TRACK, SARC_CONVERT, SARC_RELEASE} sarc_state_t;

   // Byte select low: high byte stays on the upper lanes; high: bytes swap
   function automatic logic [RESULT_W-1:0] sarc_lanes(input logic [RESULT_W-1:0] word,
                                                      input logic byte_low);
      sarc_lanes = byte_low ? {word[BYTE_W-1:0], word[RESULT_W-1:BYTE_W]} : word;
   endfunction
endpackage

/* tb/sarc_core_model.sv */
// Approximation core model: offers a fixed list of result words on a valid/ready stream
`timescale 1ns/100ps

module sarc_core_model
   import sarc_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Start offering words
   input wire logic go_in,
   // Result stream
   input wire logic ready_in,
   output logic valid_out,
   output logic [RESULT_W-1:0] data_out
);
   // -------------------------------------------------------------
   // Word list
   // -------------------------------------------------------------
   // Extremes of the two's complement range, then a plain value
   logic [RESULT_W-1:0] words [3] = '{16'h8000, 16'h7fff, 16'h1234};
   int idx = 0;
   logic [RESULT_W-1:0] junk = 16'ha5a5;

   // Data holds until taken; while valid is low the bus toggles so stale data is never reused
   assign valid_out = go_in && (idx < 3);
   assign data_out = valid_out ? words[idx] : junk;

   always @(posedge clk_in) begin
      junk <= ~junk;
      if (rst_n_in && valid_out && ready_in) begin
         idx <= idx + 1;
      end
   end
endmodule

/* tb/sar_adc_convert_read_control_test.sv */
// Self-checking bench of the convert/read control block
`timescale 1ns/100ps

module sar_adc_convert_read_control_test
   import sarc_pkg::*;
;
   // -------------------------------------------------------------
   // Signals
   // -------------------------------------------------------------
   logic clk = 1'b0;
   logic rst_n = 1'b1;
   logic cs_n = 1'b1;
   logic rc = 1'b1;
   logic bsel = 1'b0;
   logic go = 1'b0;
   logic [RESULT_W-1:0] rdata;
   logic rvalid, rready, busy_n, hold, oe_n;
   logic [RESULT_W-1:0] dout;
   int error_cnt = 0;
   int n_checks = 0;
   int cyc = 0;

   always #2 clk = ~clk;

   sarc_top DUT (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .CS_N_IN(cs_n), .RD_CONV_N_IN(rc),
      .BYTE_SEL_IN(bsel), .RESULT_DATA_IN(rdata), .RESULT_VALID_IN(rvalid),
      .RESULT_READY_OUT(rready), .BUSY_N_OUT(busy_n), .HOLD_OUT(hold), .DATA_OUT(dout),
      .DATA_OE_N_OUT(oe_n));

   sarc_core_model core (.clk_in(clk), .rst_n_in(rst_n), .go_in(go), .ready_in(rready),
      .valid_out(rvalid), .data_out(rdata));

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic cycles(input int n);
      repeat (n) @(negedge clk);
   endtask

   // Bounded wait for busy to reach a level
   task automatic wait_busy(input logic lvl, input int max);
      int i;
      i = 0;
      while (busy_n !== lvl && i < max) begin
         @(negedge clk);
         i++;
      end
      check("busy level", 16'(busy_n), 16'(lvl));
   endtask

   task automatic test_done();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   task automatic t_idle();
      check("busy after reset", 16'(busy_n), 16'h0001);
      check("hold after reset", 16'(hold), 16'h0000);
      go = 1'b1;
      rc = 1'b0;
      cycles(8);
      // Two words buffered, third still offered: the stream must stall
      check("ready when full", 16'(rready), 16'h0000);
      check("busy with select high", 16'(busy_n), 16'h0001);
      check("bus with select high", 16'(oe_n), 16'h0001);
      rc = 1'b1;
      cycles(4);
   endtask

   task automatic t_rc_start();
      cs_n = 1'b0;
      cycles(4);
      check("idle read enable", 16'(oe_n), 16'h0000);
      check("idle read data", dout, 16'h0000);
      rc = 1'b0;
      wait_busy(1'b0, 6);
      check("hold at start", 16'(hold), 16'h0001);
      check("bus at rc start", 16'(oe_n), 16'h0001);
      cycles(8);
      rc = 1'b1;
      cycles(4);
      check("read during conv", dout, 16'h0000);
      check("enable during conv", 16'(oe_n), 16'h0000);
      // Extra convert command while busy must leave no trace
      rc = 1'b0;
      cycles(10);
      rc = 1'b1;
      wait_busy(1'b1, CONV_CYC + 200);
      check("result on busy rise", dout, 16'h8000);
      check("hold at end", 16'(hold), 16'h0000);
      bsel = 1'b1;
      cycles(4);
      check("byte lanes", dout, 16'h0080);
      bsel = 1'b0;
      cycles(20);
      check("no queued start", 16'(busy_n), 16'h0001);
      // Acquisition gap before the next convert command
      cycles(650);
   endtask

   task automatic t_cs_start();
      cs_n = 1'b1;
      cycles(4);
      check("float on deselect", 16'(oe_n), 16'h0001);
      rc = 1'b0;
      cycles(3);
      cs_n = 1'b0;
      wait_busy(1'b0, 6);
      check("bus at cs start", 16'(oe_n), 16'h0001);
      // Lines kept low across busy rise: an unacquired conversion follows
      wait_busy(1'b1, CONV_CYC + 200);
      wait_busy(1'b0, 4);
      check("hold on restart", 16'(hold), 16'h0001);
      cs_n = 1'b1;
      rc = 1'b1;
      wait_busy(1'b1, CONV_CYC + 200);
      cs_n = 1'b0;
      cycles(4);
      check("third word in order", dout, 16'h1234);
      check("read enable", 16'(oe_n), 16'h0000);
      rc = 1'b0;
      cycles(12);
      check("float while rc low", 16'(oe_n), 16'h0001);
      check("busy on tied-low start", 16'(busy_n), 16'h0000);
      rc = 1'b1;
      cycles(4);
      check("previous word in conv", dout, 16'h1234);
      check("enable in conv", 16'(oe_n), 16'h0000);
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         test_done();
      end
   end

   initial begin
      // Assert reset off the clock edge so the asynchronous reset sees a real fall
      #1;
      rst_n = 1'b0;
      cycles(5);
      rst_n = 1'b1;
      cycles(6);
      t_idle();
      t_rc_start();
      t_cs_start();
      test_done();
   end
endmodule
